//--- builder_model.sv
// readout builder model draining the three injection streams
`timescale 1ns/1ps
`default_nettype none
module builder_model (
	input  wire logic        clock,            // system clock
	input  wire logic        resetn,           // async reset, active low
	input  wire logic        stall,            // hold all readies low
	input  wire logic        sync_len_valid,   // sync length shown
	input  wire logic [31:0] sync_len_data,    // sync length word
	input  wire logic        async_len_valid,  // async length shown
	input  wire logic [31:0] async_len_data,   // async length word
	input  wire logic        async_data_valid, // async word shown
	input  wire logic [31:0] async_data_data,  // async word
	output logic             sync_len_ready,   // take sync length
	output logic             async_len_ready,  // take async length
	output logic             async_data_ready  // take async word
);
	logic [31:0] sq[$];
	logic [31:0] lq[$];
	logic [31:0] dq[$];
	assign sync_len_ready = !stall;
	assign async_len_ready = !stall;
	assign async_data_ready = !stall;
	// words are taken in order on valid and ready
	always @(posedge clock) begin
		if (resetn && sync_len_valid && sync_len_ready)
			sq.push_back(sync_len_data);
		if (resetn && async_len_valid && async_len_ready)
			lq.push_back(async_len_data);
		if (resetn && async_data_valid && async_data_ready)
			dq.push_back(async_data_data);
	end
endmodule
`default_nettype wire

//--- cpu_event_injection_fifos.sv
// processor event injection buffers with register slave and builder ports
`timescale 1ns/1ps
`default_nettype none
module cpu_event_injection_fifos #(
	parameter int FIFO_DEPTH = evt_inject_pkg::fifo_depth,
	parameter int BUF_DEPTH  = evt_inject_pkg::buf_depth
) (
	input  wire logic        clock,            // 200 MHz system clock
	input  wire logic        resetn,           // async reset, active low
	input  wire logic        ctrl_reset,       // control register reset, sync
	input  wire logic [7:0]  reg_addr,         // byte address
	input  wire logic        reg_wr,           // write strobe
	input  wire logic [31:0] reg_wdata,        // write data
	input  wire logic        reg_rd,           // read strobe
	output logic      [31:0] reg_rdata,        // read data
	output logic             reg_rvalid,       // read data valid
	input  wire logic        trig_block_valid, // trigger block arrived
	input  wire logic [31:0] last_trigger_value,      // its trigger number
	output logic             sync_len_valid,   // sync length available
	input  wire logic        sync_len_ready,   // builder takes sync length
	output logic      [31:0] sync_len_data,    // sync length word
	output logic             async_len_valid,  // async event queued
	input  wire logic        async_len_ready,  // builder takes async length
	output logic      [31:0] async_len_data,   // async length word
	output logic             async_data_valid, // async data word available
	input  wire logic        async_data_ready, // builder takes async word
	output logic      [31:0] async_data_data,  // async data word
	output logic             sync_events_owed  // builder must hold block close
);
	localparam int W  = evt_inject_pkg::word_w;
	localparam int LW = evt_inject_pkg::level_w;

	generate
		if (FIFO_DEPTH > 512 || BUF_DEPTH < 2 || BUF_DEPTH > FIFO_DEPTH) begin : g_bad
			$error("cpu_event_injection_fifos: depth outside 10-bit level field");
		end
	endgenerate

	// address decode shared by the write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	stream_if #(.WIDTH(W)) sl_in ();
	stream_if #(.WIDTH(W)) sl_out ();
	stream_if #(.WIDTH(W)) al_in ();
	stream_if #(.WIDTH(W)) al_out ();
	stream_if #(.WIDTH(W)) ad_in ();
	stream_if #(.WIDTH(W)) ad_mid ();
	stream_if #(.WIDTH(W)) ad_out ();

	logic [LW-1:0] sl_level, al_level, ad_level;
	logic          sl_full, al_full, ad_full;
	logic [9:0]    pending;
	logic          sl_accepted;

	// register writes become FIFO pushes
	assign sl_in.valid = reg_wr && hit(reg_addr, evt_inject_pkg::off_sync_len_push);
	assign sl_in.data  = reg_wdata;
	assign al_in.valid = reg_wr && hit(reg_addr, evt_inject_pkg::off_async_len_push);
	assign al_in.data  = reg_wdata;
	assign ad_in.valid = reg_wr && hit(reg_addr, evt_inject_pkg::off_async_data_push);
	assign ad_in.data  = reg_wdata;
	assign sl_accepted = sl_in.valid && sl_in.ready;

	word_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .LVL_W(LW)) u_sync_len (
		.clock  (clock),
		.resetn (resetn),
		.clear  (ctrl_reset),
		.wr     (sl_in),
		.rd     (sl_out),
		.level  (sl_level),
		.full   (sl_full)
	);

	word_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .LVL_W(LW)) u_async_len (
		.clock  (clock),
		.resetn (resetn),
		.clear  (ctrl_reset),
		.wr     (al_in),
		.rd     (al_out),
		.level  (al_level),
		.full   (al_full)
	);

	word_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .LVL_W(LW)) u_async_data (
		.clock  (clock),
		.resetn (resetn),
		.clear  (ctrl_reset),
		.wr     (ad_in),
		.rd     (ad_mid),
		.level  (ad_level),
		.full   (ad_full)
	);

	// short staging buffer toward the builder; its ready stalls the big FIFO
	word_fifo #(.WIDTH(W), .DEPTH(BUF_DEPTH)) u_async_stage (
		.clock  (clock),
		.resetn (resetn),
		.clear  (ctrl_reset),
		.wr     (ad_mid),
		.rd     (ad_out),
		.level  (),
		.full   ()
	);

	pending_event_counter #(.WIDTH(10)) u_pending (
		.clock  (clock),
		.resetn (resetn),
		.clear  (ctrl_reset),
		.inc    (trig_block_valid),
		.dec    (sl_accepted),
		.count  (pending)
	);

	// builder side
	assign sync_len_valid   = sl_out.valid;
	assign sync_len_data    = sl_out.data;
	assign sl_out.ready     = sync_len_ready;
	assign async_len_valid  = al_out.valid;
	assign async_len_data   = al_out.data;
	assign al_out.ready     = async_len_ready;
	assign async_data_valid = ad_out.valid;
	assign async_data_data  = ad_out.data;
	assign ad_out.ready     = async_data_ready;
	assign sync_events_owed = (pending != '0);

	// last trigger number
	logic [31:0] trig_ff, nxt_trig;

	always_comb begin
		nxt_trig = trig_ff;
		if (ctrl_reset)
			nxt_trig = evt_inject_pkg::trigger_reset;
		else if (trig_block_valid)
			nxt_trig = last_trigger_value;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			trig_ff <= evt_inject_pkg::trigger_reset;
		else
			trig_ff <= nxt_trig;
	end

	// status words
	function automatic logic [31:0] status_word(input logic full_f, input logic [LW-1:0] lvl);
		logic [31:0] s;
		s = evt_inject_pkg::status_reset;
		s[evt_inject_pkg::full_bit] = full_f;
		s[evt_inject_pkg::level_msb:evt_inject_pkg::level_lsb] = lvl;
		status_word = s;
	endfunction

	logic [31:0] rdata_ff, nxt_rdata;
	logic        rvalid_ff, nxt_rvalid;

	always_comb begin
		nxt_rvalid = reg_rd;
		nxt_rdata  = 32'h0000_0000;
		if (reg_rd) begin
			if (hit(reg_addr, evt_inject_pkg::off_sync_len_status)) begin
				nxt_rdata = status_word(sl_full, sl_level);
				nxt_rdata[evt_inject_pkg::pending_msb:evt_inject_pkg::pending_lsb] =
					pending;
			end else if (hit(reg_addr, evt_inject_pkg::off_async_data_stat)) begin
				nxt_rdata = status_word(ad_full, ad_level);
			end else if (hit(reg_addr, evt_inject_pkg::off_async_len_stat)) begin
				nxt_rdata = status_word(al_full, al_level);
			end else if (hit(reg_addr, evt_inject_pkg::off_last_trigger)) begin
				nxt_rdata = trig_ff;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_ff  <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;
endmodule
`default_nettype wire

//--- evt_inject_pkg.sv
// shared constants for the processor event injection buffers
package evt_inject_pkg;
	localparam int          word_w          = 32;
	localparam int          fifo_depth      = 512;
	localparam int          level_w         = 10;
	localparam int          buf_depth       = 16;
	localparam int          addr_w          = 8;
	localparam logic [7:0]  off_sync_len_push   = 8'h18;
	localparam logic [7:0]  off_sync_len_status = 8'h1c;
	localparam logic [7:0]  off_async_data_push = 8'h20;
	localparam logic [7:0]  off_async_data_stat = 8'h24;
	localparam logic [7:0]  off_async_len_push  = 8'h28;
	localparam logic [7:0]  off_async_len_stat  = 8'h2c;
	localparam logic [7:0]  off_last_trigger    = 8'h40;
	localparam int          full_bit        = 31;
	localparam int          level_msb       = 9;
	localparam int          level_lsb       = 0;
	localparam int          pending_msb     = 25;
	localparam int          pending_lsb     = 16;
	localparam logic [31:0] status_reset    = 32'h0000_0000;
	localparam logic [31:0] trigger_reset   = 32'h0000_0000;
	localparam logic [9:0]  pending_reset   = 10'h000;
	localparam logic [9:0]  pending_max     = 10'h3ff;
endpackage

//--- inject_props.sv
// concurrent checks on the injection buffer ports
`timescale 1ns/1ps
`default_nettype none
module inject_props (
	input wire logic        clock,            // clock
	input wire logic        resetn,           // reset
	input wire logic        ctrl_reset,       // control reset
	input wire logic [7:0]  reg_addr,         // address
	input wire logic        reg_wr,           // write
	input wire logic        reg_rd,           // read
	input wire logic [31:0] reg_rdata,        // read data
	input wire logic        reg_rvalid,       // read valid
	input wire logic        trig_block_valid, // block pulse
	input wire logic        sync_len_valid,   // sync head
	input wire logic        sync_len_ready,   // sync take
	input wire logic [31:0] sync_len_data,    // sync word
	input wire logic        async_len_valid,  // async length head
	input wire logic        async_data_valid, // async data head
	input wire logic        sync_events_owed  // pending nonzero
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	wire wr_sync = reg_wr && reg_addr == 8'h18 && !ctrl_reset;
	wire wr_alen = reg_wr && reg_addr == 8'h28 && !ctrl_reset;
	wire wr_data = reg_wr && reg_addr == 8'h20 && !ctrl_reset;
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_idle_bus_quiet: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 32'h0)
		else $error("read data without read");
	a_block_sets_owed: assert property (trig_block_valid && !ctrl_reset && !wr_sync |=> sync_events_owed)
		else $error("block did not raise owed");
	a_owed_stays_low: assert property (!sync_events_owed && !trig_block_valid |=> !sync_events_owed)
		else $error("owed rose without block");
	a_ctrl_reset_empties: assert property (ctrl_reset |=> !sync_events_owed && !sync_len_valid && !async_len_valid && !async_data_valid)
		else $error("control reset left state");
	a_sync_len_queued: assert property (wr_sync |=> sync_len_valid)
		else $error("sync length not queued");
	a_async_len_queued: assert property (wr_alen |=> async_len_valid)
		else $error("async length not queued");
	a_data_reaches_out: assert property (wr_data && !async_data_valid |-> ##[1:2] async_data_valid)
		else $error("async word not presented");
	a_head_holds_stall: assert property (sync_len_valid && !sync_len_ready && !ctrl_reset |=> sync_len_valid && $stable(sync_len_data))
		else $error("sync head changed while stalled");
	cover property (wr_sync && sync_events_owed);
	cover property (sync_len_valid && sync_len_ready);
	cover property (async_data_valid && !sync_len_ready);
	cover property (trig_block_valid && wr_sync);
endmodule
bind cpu_event_injection_fifos inject_props chk_u (.clock(clock), .resetn(resetn),
	.ctrl_reset(ctrl_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .trig_block_valid(trig_block_valid),
	.sync_len_valid(sync_len_valid), .sync_len_ready(sync_len_ready),
	.sync_len_data(sync_len_data), .async_len_valid(async_len_valid),
	.async_data_valid(async_data_valid), .sync_events_owed(sync_events_owed));
`default_nettype wire

//--- pending_event_counter.sv
// count of trigger blocks still waiting for a synchronous length
`timescale 1ns/1ps
`default_nettype none
module pending_event_counter #(
	parameter int WIDTH = 10
) (
	input  wire logic             clock,    // system clock
	input  wire logic             resetn,   // async reset, active low
	input  wire logic             clear,    // control reset
	input  wire logic             inc,      // trigger block arrived
	input  wire logic             dec,      // sync length accepted
	output logic     [WIDTH-1:0]  count     // pending blocks
);
	generate
		if (WIDTH < 1 || WIDTH > 10) begin : g_bad
			$error("pending_event_counter: WIDTH must fit the status field");
		end
	endgenerate

	logic [WIDTH-1:0] cnt_ff, nxt_cnt;

	assign count = cnt_ff;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (clear)
			nxt_cnt = '0;
		else if (inc && !dec && cnt_ff != '1)
			nxt_cnt = cnt_ff + WIDTH'(1);
		else if (dec && !inc && cnt_ff != '0)
			nxt_cnt = cnt_ff - WIDTH'(1);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end
endmodule
`default_nettype wire

//--- stream_if.sv
// valid/ready word carrier between the buffer modules
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 32);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport fill  (input valid, input data, output ready);
	modport drain (output valid, output data, input ready);
	modport src   (output valid, output data, input ready);
	modport snk   (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- tb_top.sv
// register level test of the event injection buffers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock, resetn = 0, ctrl_reset = 0, reg_wr = 0, reg_rd = 0;
	logic        trig_block_valid = 0, stall = 1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, last_trigger_value = 32'h0;
	wire logic [31:0] reg_rdata, sync_len_data, async_len_data, async_data_data;
	wire logic   reg_rvalid, sync_len_valid, sync_len_ready, async_len_valid;
	wire logic   async_len_ready, async_data_valid, async_data_ready, sync_events_owed;
	int          n_errors = 0, n_tests = 0;
	localparam logic [7:0] offs [8] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h40, 8'h30};
	localparam int n_data = evt_inject_pkg::fifo_depth + evt_inject_pkg::buf_depth;
	cpu_event_injection_fifos dut_u (.clock(clock), .resetn(resetn), .ctrl_reset(ctrl_reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .trig_block_valid(trig_block_valid),
		.last_trigger_value(last_trigger_value), .sync_len_valid(sync_len_valid),
		.sync_len_ready(sync_len_ready), .sync_len_data(sync_len_data),
		.async_len_valid(async_len_valid), .async_len_ready(async_len_ready),
		.async_len_data(async_len_data), .async_data_valid(async_data_valid),
		.async_data_ready(async_data_ready), .async_data_data(async_data_data),
		.sync_events_owed(sync_events_owed));
	builder_model partner_u (.clock(clock), .resetn(resetn), .stall(stall),
		.sync_len_valid(sync_len_valid), .sync_len_data(sync_len_data),
		.async_len_valid(async_len_valid), .async_len_data(async_len_data),
		.async_data_valid(async_data_valid), .async_data_data(async_data_data),
		.sync_len_ready(sync_len_ready), .async_len_ready(async_len_ready),
		.async_data_ready(async_data_ready));
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
		chk("rdata", reg_rdata, exp);
	endtask
	task trig(input logic [31:0] n);
		@(posedge clock);
		trig_block_valid <= 1'b1;
		last_trigger_value <= n;
		@(posedge clock);
		trig_block_valid <= 1'b0;
	endtask
	task test_done;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		foreach (offs[i]) rd(offs[i], 32'h0);
		for (int i = 1; i <= 3; i++) trig(32'h100 + i);
		rd(8'h1c, 32'h0003_0000);
		rd(8'h40, 32'h0000_0103);
		chk("owed", {31'h0, sync_events_owed}, 32'h1);
		wr(8'h18, 32'h0);
		rd(8'h1c, 32'h0002_0001);
		for (int i = 1; i < 512; i++) wr(8'h18, i);
		rd(8'h1c, 32'h8000_0200);
		wr(8'h18, 32'hdead_0000);
		rd(8'h1c, 32'h8000_0200);
		for (int i = 0; i < 512; i++) wr(8'h28, i + 1);
		rd(8'h2c, 32'h8000_0200);
		wr(8'h28, 32'hdead_0000);
		rd(8'h2c, 32'h8000_0200);
		for (int i = 0; i < n_data; i++) wr(8'h20, 32'ha000_0000 + i);
		rd(8'h24, 32'h8000_0200);
		wr(8'h20, 32'hdead_0000);
		rd(8'h24, 32'h8000_0200);
		stall <= 1'b0;
		for (int k = 0; k < 2000 && (sync_len_valid | async_len_valid | async_data_valid); k++)
			@(posedge clock);
		chk("data count", partner_u.dq.size(), n_data);
		chk("length count", partner_u.lq.size(), 512);
		chk("sync count", partner_u.sq.size(), 512);
		foreach (partner_u.dq[i]) chk("data", partner_u.dq[i], 32'ha000_0000 + i);
		foreach (partner_u.lq[i]) chk("async len", partner_u.lq[i], i + 1);
		foreach (partner_u.sq[i]) chk("sync len", partner_u.sq[i], i);
		chk("owed", {31'h0, sync_events_owed}, 32'h0);
		rd(8'h24, 32'h0);
		stall <= 1'b1;
		trig(32'h55);
		trig(32'h56);
		wr(8'h18, 32'h7);
		// block and accepted length in one cycle leave the pending count alone
		@(posedge clock);
		trig_block_valid <= 1'b1;
		last_trigger_value <= 32'h57;
		reg_wr <= 1'b1;
		reg_addr <= 8'h18;
		reg_wdata <= 32'h9;
		@(posedge clock);
		trig_block_valid <= 1'b0;
		reg_wr <= 1'b0;
		rd(8'h1c, 32'h0001_0002);
		rd(8'h40, 32'h0000_0057);
		wr(8'h28, 32'h3);
		rd(8'h2c, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			rd(8'h24, 32'h0);
			wr(8'h20, 32'hb000_0000 + i);
		end
		chk("async valid", {31'h0, async_data_valid}, 32'h1);
		@(posedge clock);
		ctrl_reset <= 1'b1;
		@(posedge clock);
		ctrl_reset <= 1'b0;
		foreach (offs[i]) rd(offs[i], 32'h0);
		chk("async valid", {31'h0, async_data_valid}, 32'h0);
		chk("owed", {31'h0, sync_events_owed}, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire

//--- word_fifo.sv
// parameterised first-in first-out word buffer with fill level
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 512,
	parameter int LVL_W = $clog2(DEPTH) + 1
) (
	input  wire logic             clock,    // system clock
	input  wire logic             resetn,   // async reset, active low
	input  wire logic             clear,    // synchronous empty
	stream_if.fill                wr,       // filling side
	stream_if.drain               rd,       // draining side
	output logic     [LVL_W-1:0]  level,    // words held
	output logic                  full      // no room left
);
	localparam int PTR_W = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("word_fifo: DEPTH must be a power of two >= 2");
		end
		// the level must be able to show a completely full buffer
		if (LVL_W < $clog2(DEPTH) + 1) begin : g_bad_lvl
			$error("word_fifo: LVL_W too narrow for DEPTH");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
	logic [LVL_W-1:0] cnt_ff, nxt_cnt;
	logic             do_wr, do_rd;

	assign full     = (cnt_ff == LVL_W'(DEPTH));
	assign level    = cnt_ff;
	assign wr.ready = !full;
	assign rd.valid = (cnt_ff != '0);
	assign rd.data  = mem[rptr_ff];
	// a push while full is dropped here: the write pointer and memory stay put
	assign do_wr    = wr.valid && !full;
	assign do_rd    = rd.valid && rd.ready;

	always_comb begin
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_cnt  = cnt_ff;
		if (clear) begin
			nxt_wptr = '0;
			nxt_rptr = '0;
			nxt_cnt  = '0;
		end else begin
			if (do_wr)
				nxt_wptr = wptr_ff + PTR_W'(1);
			if (do_rd)
				nxt_rptr = rptr_ff + PTR_W'(1);
			if (do_wr && !do_rd)
				nxt_cnt = cnt_ff + LVL_W'(1);
			else if (do_rd && !do_wr)
				nxt_cnt = cnt_ff - LVL_W'(1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
		end
	end

	always_ff @(posedge clock) begin
		if (do_wr && !clear)
			mem[wptr_ff] <= wr.data;
	end
endmodule
`default_nettype wire
